/* logic/rhs_defs.vh */
// Purpose: Shared constants for the reset and hibernate sequencer.
// Assumes: Core clock of 20 MHz.
// Notes:   Times in their own units; cycle counts derived from them.
`ifndef RHS_DEFS_VH
`define RHS_DEFS_VH

`define RHS_CLK_HZ           20000000
// Hardware wake-up after reset release, ms
`define RHS_T_HW_WAKE_MS     25
// Crystal settling, firmware start and calibration, ms
`define RHS_T_INIT_XTAL_MS   1350
// Firmware start and calibration with external slow clock, ms
`define RHS_T_INIT_EXT_MS    250
// Wake from hibernate, ms
`define RHS_T_WAKE_HIB_MS    50
// Extra calibration after large temperature shift, ms
`define RHS_T_RECAL_MS       200
// Shortest hibernate pulse not flagged as short; shorter pulses still enter hibernate, ms
`define RHS_T_HIB_MIN_MS     10
`define RHS_MS_CYC           (`RHS_CLK_HZ / 1000)

// Phase codes (one-hot)
`define RHS_ST_W             6
`define RHS_ST_OFF           6'h01
`define RHS_ST_HWWAKE        6'h02
`define RHS_ST_INIT          6'h04
`define RHS_ST_READY         6'h08
`define RHS_ST_HIB           6'h10
`define RHS_ST_HIBWAKE       6'h20

`endif

/* logic/rhs_timer.v */
// Purpose: Down counter that times one sequencer phase.
// Assumes: Load wins over counting.
// Notes:   done is high while the count stands at zero.
`timescale 1ns/100ps
module rhs_timer #(
  parameter W = 32
) (
  // Clock and reset
  input  wire         core_clk,
  input  wire         rst_n,
  // Control
  input  wire         load,
  input  wire [W-1:0] load_val,
  // Status
  output wire         done
);

  reg [W-1:0] cnt_q;

  always @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_q <= {W{1'b0}};
    end else if (load) begin
      cnt_q <= load_val;
    end else if (cnt_q != {W{1'b0}}) begin
      cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign done = (cnt_q == {W{1'b0}});

endmodule

/* logic/rhs_sequencer.v */
// Overview of operation
// - With a slow crystal, wake-up is 25 ms then 1.35 s of initialization.
// - With an external slow clock, initialization is 250 ms after wake-up.
// - After hibernate release the device is ready after 50 ms.
// - Wake from hibernate takes 200 ms longer after a large temperature shift.
// - The slow oscillator keeps running during hibernate by default.
// - The device uses a 32.768 kHz slow clock and a 40 MHz fast clock.
// - The device drives an enable for an external fast oscillator.
//
// Purpose: Reset, hibernate entry and wake-up sequencer of the device.
// Assumes: All inputs synchronous to core_clk; rst_n is the core reset.
// Notes:   Phase lengths are parameters so simulation can shorten them.
`timescale 1ns/100ps
`include "rhs_defs.vh"
module rhs_sequencer #(
  parameter HW_WAKE_CYC   = `RHS_T_HW_WAKE_MS   * `RHS_MS_CYC,
  parameter INIT_XTAL_CYC = `RHS_T_INIT_XTAL_MS * `RHS_MS_CYC,
  parameter INIT_EXT_CYC  = `RHS_T_INIT_EXT_MS  * `RHS_MS_CYC,
  parameter WAKE_HIB_CYC  = `RHS_T_WAKE_HIB_MS  * `RHS_MS_CYC,
  parameter RECAL_CYC     = `RHS_T_RECAL_MS     * `RHS_MS_CYC,
  parameter HIB_MIN_CYC   = `RHS_T_HIB_MIN_MS   * `RHS_MS_CYC
) (
  // Clock and reset
  input  wire core_clk,
  input  wire rst_n,
  // Host control lines
  input  wire device_reset_n,
  input  wire hibernate_request_n,
  input  wire orderly_stop_request,
  // Board and environment straps
  input  wire ext_slow_clk_sel,
  input  wire slow_osc_off_in_hib,
  input  wire temp_shift_flag,
  // Status and clock control
  output reg  device_ready,
  output reg  fast_osc_enable,
  output reg  slow_osc_enable,
  output reg  hibernated,
  output reg  stop_ack,
  output reg  short_hib_seen
);

  localparam TW = 32;

  // One-hot phase codes
  localparam [`RHS_ST_W-1:0] PH_OFF     = `RHS_ST_OFF;
  localparam [`RHS_ST_W-1:0] PH_HWWAKE  = `RHS_ST_HWWAKE;
  localparam [`RHS_ST_W-1:0] PH_INIT    = `RHS_ST_INIT;
  localparam [`RHS_ST_W-1:0] PH_READY   = `RHS_ST_READY;
  localparam [`RHS_ST_W-1:0] PH_HIB     = `RHS_ST_HIB;
  localparam [`RHS_ST_W-1:0] PH_HIBWAKE = `RHS_ST_HIBWAKE;

  reg [`RHS_ST_W-1:0] st_q;
  reg [`RHS_ST_W-1:0] st_d;
  reg                 ld;
  reg [TW-1:0]        ld_val;
  reg [TW-1:0]        init_len;
  reg [TW-1:0]        wake_len;
  reg                 recal_q;
  reg [TW-1:0]        hib_cnt_q;
  wire                t_done;
  wire                ready_d;
  wire                fast_osc_d;
  wire                slow_osc_d;
  wire                hib_d;
  wire                stop_ack_d;

  rhs_timer #(
    .W (TW)
  ) u_timer (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .load     (ld),
    .load_val (ld_val),
    .done     (t_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Phase lengths

  // Boot initialization depends on how the slow clock is supplied
  always @* begin
    init_len = INIT_XTAL_CYC[TW-1:0];
    if (ext_slow_clk_sel) begin
      init_len = INIT_EXT_CYC[TW-1:0];
    end
  end

  // Extra calibration time after a big temperature change
  always @* begin
    wake_len = WAKE_HIB_CYC[TW-1:0];
    if (recal_q) begin
      wake_len = WAKE_HIB_CYC[TW-1:0] + RECAL_CYC[TW-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase sequencing

  always @* begin
    st_d   = st_q;
    ld     = 1'b0;
    ld_val = {TW{1'b0}};
    if (!device_reset_n) begin
      // Reset pulse width is the host's duty; any low restarts
      st_d = PH_OFF;
    end else begin
      case (st_q)
        PH_OFF: begin
          st_d   = PH_HWWAKE;
          ld     = 1'b1;
          ld_val = HW_WAKE_CYC[TW-1:0];
        end
        PH_HWWAKE: begin
          if (t_done) begin
            st_d   = PH_INIT;
            ld     = 1'b1;
            ld_val = init_len;
          end
        end
        PH_INIT, PH_HIBWAKE: begin
          if (!hibernate_request_n) begin
            st_d = PH_HIB;
          end else if (t_done) begin
            st_d = PH_READY;
          end
        end
        PH_READY: begin
          if (!hibernate_request_n) begin
            st_d = PH_HIB;
          end
        end
        PH_HIB: begin
          if (hibernate_request_n) begin
            st_d   = PH_HIBWAKE;
            ld     = 1'b1;
            ld_val = wake_len;
          end
        end
        default: begin
          st_d = PH_OFF;
        end
      endcase
    end
  end

  always @(posedge core_clk) begin
    if (!rst_n) begin
      st_q <= PH_OFF;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Temperature latch and hibernate pulse width watch

  always @(posedge core_clk) begin
    if (!rst_n) begin
      recal_q        <= 1'b0;
      hib_cnt_q      <= {TW{1'b0}};
      short_hib_seen <= 1'b0;
    end else begin
      // Set wins; consumed when a wake loads its length, so a shift seen
      // while waking is kept for the next wake
      if (temp_shift_flag) begin
        recal_q <= 1'b1;
      end else if (st_q == PH_HIB && st_d == PH_HIBWAKE) begin
        recal_q <= 1'b0;
      end
      if (!hibernate_request_n) begin
        if (hib_cnt_q != HIB_MIN_CYC[TW-1:0]) begin
          hib_cnt_q <= hib_cnt_q + {{(TW-1){1'b0}}, 1'b1};
        end
      end else begin
        hib_cnt_q <= {TW{1'b0}};
      end
      // Flags a hibernate pulse below the minimum width; sticky to reset
      if (st_q == `RHS_ST_HIB && hibernate_request_n &&
          hib_cnt_q != HIB_MIN_CYC[TW-1:0]) begin
        short_hib_seen <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next values of the outputs

  // Host waits on this before any traffic
  assign ready_d    = (st_d == PH_READY);
  // Fast oscillator runs only when the core is awake, to save power
  assign fast_osc_d = (st_d != PH_OFF) &&
                      (st_d != PH_HIB);
  // The slow clock keeps the real-time counter alive, so it stays on
  // through hibernate unless the board strap stops it
  assign slow_osc_d = (st_d != PH_OFF) &&
                      !((st_d == PH_HIB) &&
                        slow_osc_off_in_hib);
  assign hib_d      = (st_d == PH_HIB);
  // Acknowledge the stop so the host may toggle reset
  assign stop_ack_d = orderly_stop_request &&
                      (st_q == PH_READY);

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs

  always @(posedge core_clk) begin
    if (!rst_n) begin
      device_ready    <= 1'b0;
      fast_osc_enable <= 1'b0;
      slow_osc_enable <= 1'b0;
      hibernated      <= 1'b0;
      stop_ack        <= 1'b0;
    end else begin
      device_ready    <= ready_d;
      fast_osc_enable <= fast_osc_d;
      slow_osc_enable <= slow_osc_d;
      hibernated      <= hib_d;
      stop_ack        <= stop_ack_d;
    end
  end

endmodule

/* sim/rhs_seq_sva.sv */
// Purpose: Port checks of the reset and hibernate sequencer.
// Assumes: Straps held still through each boot.
// Notes:   Counters time the reset and hibernate lines since their release.
`timescale 1ns/100ps
module rhs_seq_sva #(
  parameter int HW_WAKE_CYC = 20, INIT_XTAL_CYC = 40, INIT_EXT_CYC = 30,
  parameter int WAKE_HIB_CYC = 25, RECAL_CYC = 15
) (
  input wire core_clk, rst_n, device_reset_n, hibernate_request_n,
  input wire orderly_stop_request, ext_slow_clk_sel, slow_osc_off_in_hib,
  input wire device_ready, fast_osc_enable, slow_osc_enable, hibernated,
  input wire stop_ack
);
  int since_q, hib_q, boot_lo;
  assign boot_lo = HW_WAKE_CYC +
                   (ext_slow_clk_sel ? INIT_EXT_CYC : INIT_XTAL_CYC);
  always @(posedge core_clk) begin
    since_q <= (rst_n && device_reset_n) ? since_q + 1 : 0;
    hib_q <= (rst_n && hibernate_request_n) ? hib_q + 1 : 0;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_off;
    !device_reset_n |=> !device_ready && !fast_osc_enable && !hibernated;
  endproperty
  a_off: assert property (p_off) else $error("not off in reset");
  property p_hib;
    device_ready && device_reset_n && !hibernate_request_n
      |=> hibernated && !device_ready && !fast_osc_enable;
  endproperty
  a_hib: assert property (p_hib) else $error("no hibernate");
  property p_slow;
    hibernated && $past(hibernated)
      |-> slow_osc_enable == !$past(slow_osc_off_in_hib);
  endproperty
  a_slow: assert property (p_slow) else $error("slow osc wrong");
  property p_run;
    device_ready |-> fast_osc_enable && slow_osc_enable;
  endproperty
  a_run: assert property (p_run) else $error("clock off in ready");
  property p_ack;
    stop_ack == ($past(device_ready) && $past(orderly_stop_request));
  endproperty
  a_ack: assert property (p_ack) else $error("stop ack wrong");
  property p_boot_lo;
    device_ready |-> since_q >= boot_lo;
  endproperty
  a_boot_lo: assert property (p_boot_lo) else $error("boot early");
  property p_boot_hi;
    since_q == boot_lo + 4 && hib_q >= since_q |-> device_ready;
  endproperty
  a_boot_hi: assert property (p_boot_hi) else $error("boot late");
  property p_hib_hi;
    hib_q == WAKE_HIB_CYC + RECAL_CYC + 4 && since_q > hib_q |-> device_ready;
  endproperty
  a_hib_hi: assert property (p_hib_hi) else $error("wake late");
endmodule
bind rhs_sequencer rhs_seq_sva #(.HW_WAKE_CYC(HW_WAKE_CYC),
  .INIT_XTAL_CYC(INIT_XTAL_CYC), .INIT_EXT_CYC(INIT_EXT_CYC),
  .WAKE_HIB_CYC(WAKE_HIB_CYC), .RECAL_CYC(RECAL_CYC)) u_sva (.*);

/* sim/rhs_host_model.sv */
// Purpose: Host controller driving the reset and hibernate lines.
// Assumes: Called just after a core_clk rising edge.
// Notes:   Pulse lengths are scaled down cycle counts.
`timescale 1ns/100ps
module rhs_host_model (
  input wire core_clk, device_ready,
  output logic device_reset_n = 1'b0, hibernate_request_n = 1'b1,
  output logic orderly_stop_request = 1'b0
);
  task automatic hold(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Supplies and slow clock settle while reset stays low
  task automatic power_up(input int n);
    device_reset_n <= 1'b0;
    hold(n);
    device_reset_n <= 1'b1;
  endtask
  task automatic restart(input int n);
    orderly_stop_request <= 1'b1;
    hold(2);
    orderly_stop_request <= 1'b0;
    hibernate_request_n <= 1'b1;
    device_reset_n <= 1'b0;
    hold(n);
    device_reset_n <= 1'b1;
  endtask
  task automatic hib_pulse(input int n);
    device_reset_n <= 1'b1;
    hibernate_request_n <= 1'b0;
    hold(n);
    hibernate_request_n <= 1'b1;
  endtask
  // No host traffic before the device reports ready
  task automatic wait_ready();
    for (int i = 0; i < 4000 && device_ready !== 1'b1; i++) hold(1);
  endtask
endmodule

/* sim/tb_top.sv */
// Purpose: Self-checking bench of the sequencer.
// Assumes: Phase lengths scaled to a few tens of cycles.
// Notes:   Ready latency notes are queued by the driver.
`timescale 1ns/100ps
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin errors++; \
  $display("[FAIL] %s exp %0d got %0d", nm, e, s); end end
module tb_top;
  localparam int HW = 20, XT = 40, EX = 30, WK = 25, RC = 15, HM = 12;
  logic core_clk = 0, rst_n = 0, ext_slow_clk_sel = 0;
  logic slow_osc_off_in_hib = 0, temp_shift_flag = 0;
  wire device_reset_n, hibernate_request_n, orderly_stop_request;
  wire device_ready, fast_osc_enable, slow_osc_enable, hibernated;
  wire stop_ack, short_hib_seen;
  int errors = 0, n_checks = 0, lat = 0, lo, t, seed = 67889;
  int exp_q[$];
  bit rdy_q = 0, stop_q = 0;
  always #25 core_clk = ~core_clk;
  rhs_sequencer #(.HW_WAKE_CYC(HW), .INIT_XTAL_CYC(XT), .INIT_EXT_CYC(EX),
    .WAKE_HIB_CYC(WK), .RECAL_CYC(RC), .HIB_MIN_CYC(HM)) dut (.*);
  rhs_host_model host (.core_clk, .device_ready, .device_reset_n,
    .hibernate_request_n, .orderly_stop_request);
  task automatic conclude();
    if (errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge core_clk) begin
    lat <= (device_reset_n && hibernate_request_n) ? lat + 1 : 0;
    rdy_q <= device_ready;
    stop_q <= orderly_stop_request && device_ready;
    if (rst_n) `CHK("stop_ack", stop_q, stop_ack)
    if (device_ready === 1'b1 && !rdy_q) begin
      lo = exp_q.size() ? exp_q.pop_front() : -99;
      `CHK("ready_early", 1'b1, lat >= lo)
      `CHK("ready_late", 1'b1, lat <= lo + 4)
    end
    if (hibernated === 1'b1) begin
      `CHK("fast_osc", 1'b0, fast_osc_enable)
      `CHK("slow_osc", !slow_osc_off_in_hib, slow_osc_enable)
    end
  end
  initial begin
    repeat (4000) @(posedge core_clk);
    errors++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    exp_q.push_back(HW + XT);
    host.power_up(20);
    host.wait_ready();
    ext_slow_clk_sel <= 1'b1;
    exp_q.push_back(HW + EX);
    host.restart(HM + 2);
    host.wait_ready();
    for (int i = 0; i < 4; i++) begin
      t = $random(seed) & 1;
      slow_osc_off_in_hib <= i[1];
      temp_shift_flag <= t[0];
      @(posedge core_clk);
      temp_shift_flag <= 1'b0;
      exp_q.push_back(WK + (t[0] ? RC : 0));
      host.hib_pulse(HM + ($random(seed) & 7) * i);
      host.wait_ready();
      repeat (6) @(posedge core_clk);
    end
    `CHK("no_short", 1'b0, short_hib_seen)
    host.hib_pulse(HM - 5);
    repeat (3) @(posedge core_clk);
    `CHK("short_hib", 1'b1, short_hib_seen)
    conclude();
  end
endmodule
